// *** siu_pkg.sv ***
// Shared constants for the subtract instruction unit
package siu_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] SIU_REG_CTRL      = 8'h00;
   localparam logic [7:0] SIU_REG_INSN      = 8'h04;
   localparam logic [7:0] SIU_REG_WORK      = 8'h08;
   localparam logic [7:0] SIU_REG_BANK      = 8'h0c;
   localparam logic [7:0] SIU_REG_INDEX     = 8'h10;
   localparam logic [7:0] SIU_REG_STATUS    = 8'h14;
   localparam logic [7:0] SIU_REG_MEM_ADDR  = 8'h18;
   localparam logic [7:0] SIU_REG_MEM_DATA  = 8'h1c;

   // ==========================================================
   // Field positions
   localparam int SIU_CTRL_EXT_BIT    = 0;
   localparam int SIU_STAT_C_BIT      = 0;
   localparam int SIU_STAT_DC_BIT     = 1;
   localparam int SIU_STAT_Z_BIT      = 2;
   localparam int SIU_STAT_OV_BIT     = 3;
   localparam int SIU_STAT_N_BIT      = 4;
   localparam int SIU_STAT_BUSY_BIT   = 8;
   localparam int SIU_INSN_D_BIT      = 9;
   localparam int SIU_INSN_A_BIT      = 8;

   // ==========================================================
   // Widths and encodings
   localparam int SIU_ADDR_W          = 12;
   localparam int SIU_DEPTH           = 4096;
   localparam logic [7:0] SIU_OP_LIT_MINUS_W  = 8'h08;
   localparam logic [5:0] SIU_OP_FILE_MINUS_W = 6'h17;
   localparam logic [7:0] SIU_ACCESS_LOW_MAX  = 8'h5f;
   localparam logic [3:0] SIU_ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] SIU_ACCESS_HIGH_BANK = 4'hf;

   // ==========================================================
   // Reset values
   localparam logic [15:0] SIU_INSN_RST  = 16'h0000;
   localparam logic [7:0]  SIU_BYTE_RST  = 8'h00;
   localparam logic [3:0]  SIU_BANK_RST  = 4'h0;
   localparam logic [11:0] SIU_ADDR_RST  = 12'h000;
   localparam logic [4:0]  SIU_FLAGS_RST = 5'h00;

   typedef enum logic [2:0] {
      SIU_IDLE = 3'b000,
      SIU_Q1   = 3'b001,
      SIU_Q2   = 3'b010,
      SIU_Q3   = 3'b011,
      SIU_Q4   = 3'b100
   } siu_phase_e;

endpackage : siu_pkg

// *** siu_mem.sv ***
// Data memory of file registers, registered read port
`timescale 1ns/100ps
module siu_mem
   import siu_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  wr_en,
   input  wire logic [SIU_ADDR_W-1:0] addr,
   input  wire logic [7:0]            wdata,
   output logic      [7:0]            rdata
);

   logic [7:0] mem [0:SIU_DEPTH-1];

   // No reset on the array; contents are undefined until written
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end

endmodule : siu_mem

// *** siu_top.sv ***
// Subtract instruction unit: APB registers, four-phase execution, file memory
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/100ps
// Contract
// - Literal subtract: literal minus working register, result into working register.
// - File subtract: file register minus working register, two's complement.
// - Destination bit 0: result to working register, file register untouched.
// - Destination bit 1: result written back into the addressed file register.
// - Access bit 0: address resolves into the access bank.
// - Access bit 1: bank select register picks the bank.
// - Access 0 with extended set and address up to 95: indexed offset.
module siu_top
   import siu_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   // ==========================================================
   // Functions
   // Result in [7:0], then C, DC, Z, OV, N in [12:8]
   function automatic logic [12:0] sub_flags(input logic [7:0] minu, input logic [7:0] subt);
      logic [8:0] full;
      logic [4:0] low;
      logic [7:0] res;
      full = {1'b0, minu} + {1'b0, ~subt} + 9'h001;
      low  = {1'b0, minu[3:0]} + {1'b0, ~subt[3:0]} + 5'h01;
      res  = full[7:0];
      sub_flags = {res[7], (minu[7] != subt[7]) & (res[7] != minu[7]),
                   res == 8'h00, low[4], full[8], res};
   endfunction : sub_flags

   function automatic logic [SIU_ADDR_W-1:0] resolve(input logic [7:0] f,
                                                     input logic a,
                                                     input logic ext,
                                                     input logic [3:0] bank,
                                                     input logic [11:0] base);
      if (a) begin
         resolve = {bank, f};
      end else if (ext && (f <= SIU_ACCESS_LOW_MAX)) begin
         resolve = base + {4'h0, f};
      end else if (f <= SIU_ACCESS_LOW_MAX) begin
         resolve = {SIU_ACCESS_LOW_BANK, f};
      end else begin
         resolve = {SIU_ACCESS_HIGH_BANK, f};
      end
   endfunction : resolve

   // ==========================================================
   // State
   siu_phase_e  phase;
   siu_phase_e  next_phase;
   logic        ext_en;
   logic [15:0] insn;
   logic [7:0]  work;
   logic [3:0]  bank_select_register;
   logic [11:0] index_base;
   logic [11:0] mem_addr;
   logic [4:0]  flags;
   logic [7:0]  operand;
   logic [7:0]  result;
   logic [4:0]  result_flags;
   logic        idle_q;
   logic        rdy;
   logic        err;
   logic [7:0]  mem_rdata;

   // ==========================================================
   // Decode
   wire         is_lit      = insn[15:8] == SIU_OP_LIT_MINUS_W;
   wire         is_file     = insn[15:10] == SIU_OP_FILE_MINUS_W;
   wire         dest_file   = insn[SIU_INSN_D_BIT];
   wire         access_sel  = insn[SIU_INSN_A_BIT];
   wire         idle        = phase == SIU_IDLE;
   wire [11:0]  file_addr   = resolve(insn[7:0], access_sel, ext_en,
                                      bank_select_register, index_base);
   wire [12:0]  diff        = sub_flags(operand, work);
   wire         core_wr     = (phase == SIU_Q4) && is_file && dest_file;
   wire         acc         = psel && penable;
   wire         done        = acc && rdy;
   wire         wr_done     = done && pwrite && !err;
   wire         hit_ctrl    = paddr == SIU_REG_CTRL;
   wire         hit_insn    = paddr == SIU_REG_INSN;
   wire         hit_work    = paddr == SIU_REG_WORK;
   wire         hit_bank    = paddr == SIU_REG_BANK;
   wire         hit_index   = paddr == SIU_REG_INDEX;
   wire         hit_status  = paddr == SIU_REG_STATUS;
   wire         hit_maddr   = paddr == SIU_REG_MEM_ADDR;
   wire         hit_mdata   = paddr == SIU_REG_MEM_DATA;
   wire         mapped      = hit_ctrl | hit_insn | hit_work | hit_bank | hit_index |
                              hit_status | hit_maddr | hit_mdata;
   wire         sw_mem_wr   = wr_done && hit_mdata;
   wire         start       = wr_done && hit_insn;
   // Memory port goes to the core while it runs, to software otherwise
   wire [11:0]  m_addr      = idle ? mem_addr : file_addr;
   wire         m_wr        = idle ? sw_mem_wr : core_wr;
   wire [7:0]   m_wdata     = idle ? pwdata[7:0] : result;

   wire [31:0]  rd_mux =
      hit_ctrl   ? {31'h0, ext_en} :
      hit_insn   ? {16'h0, insn} :
      hit_work   ? {24'h0, work} :
      hit_bank   ? {28'h0, bank_select_register} :
      hit_index  ? {20'h0, index_base} :
      hit_status ? {23'h0, !idle, 3'h0, flags} :
      hit_maddr  ? {20'h0, mem_addr} :
      hit_mdata  ? {24'h0, mem_rdata} : 32'h0;

   assign pready  = rdy;
   assign pslverr = rdy && err;

   siu_mem u_mem (
      .mclk  (mclk),
      .wr_en (m_wr),
      .addr  (m_addr),
      .wdata (m_wdata),
      .rdata (mem_rdata)
   );

   // ==========================================================
   // Four phases: decode, read operand, process, write back
   always_comb begin
      case (phase)
         SIU_IDLE: next_phase = start ? SIU_Q1 : SIU_IDLE;
         SIU_Q1:   next_phase = SIU_Q2;
         SIU_Q2:   next_phase = SIU_Q3;
         SIU_Q3:   next_phase = SIU_Q4;
         SIU_Q4:   next_phase = SIU_IDLE;
         default:  next_phase = SIU_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         phase <= SIU_IDLE;
      end else begin
         phase <= next_phase;
      end
   end

   // ==========================================================
   // APB handshake: one wait state; stalls while the core runs and
   // for one cycle after, so the memory read port has settled
   always_ff @(posedge mclk) begin
      if (rst) begin
         idle_q <= 1'b1;
         rdy    <= 1'b0;
         err    <= 1'b0;
         prdata <= 32'h0;
      end else begin
         idle_q <= idle;
         rdy    <= acc && !rdy && idle && idle_q;
         err    <= !mapped || (pwrite && hit_status);
         if (acc && !rdy) begin
            prdata <= pwrite ? 32'h0 : rd_mux;
         end
      end
   end

   // ==========================================================
   // Operand path
   always_ff @(posedge mclk) begin
      if (rst) begin
         operand      <= SIU_BYTE_RST;
         result       <= SIU_BYTE_RST;
         result_flags <= SIU_FLAGS_RST;
      end else begin
         if (phase == SIU_Q2) begin
            operand <= is_lit ? insn[7:0] : mem_rdata;
         end
         if (phase == SIU_Q3) begin
            result       <= diff[7:0];
            result_flags <= diff[12:8];
         end
      end
   end

   // ==========================================================
   // Software registers and write back
   always_ff @(posedge mclk) begin
      if (rst) begin
         ext_en               <= 1'b0;
         insn                 <= SIU_INSN_RST;
         work                 <= SIU_BYTE_RST;
         bank_select_register <= SIU_BANK_RST;
         index_base           <= SIU_ADDR_RST;
         mem_addr             <= SIU_ADDR_RST;
         flags                <= SIU_FLAGS_RST;
      end else if (phase == SIU_Q4) begin
         // Unknown opcodes pass the four phases without effect
         if (is_lit || (is_file && !dest_file)) begin
            work <= result;
         end
         if (is_lit || is_file) begin
            flags <= result_flags;
         end
      end else if (wr_done) begin
         if (hit_ctrl) begin
            ext_en <= pwdata[SIU_CTRL_EXT_BIT];
         end
         if (hit_insn) begin
            insn <= pwdata[15:0];
         end
         if (hit_work) begin
            work <= pwdata[7:0];
         end
         if (hit_bank) begin
            bank_select_register <= pwdata[3:0];
         end
         if (hit_index) begin
            index_base <= pwdata[11:0];
         end
         if (hit_maddr) begin
            mem_addr <= pwdata[11:0];
         end
      end
   end

endmodule : siu_top

// *** siu_top_props.sv ***
// Port checker for the subtract instruction unit
`timescale 1ns/100ps
module siu_top_props
   import siu_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // ==========================================================
   // Transfer steps
   sequence s_first_access;
      psel && penable && !$past(penable);
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence
   property p_ready_in_access;
      pready |-> psel && penable;
   endproperty
   a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   property p_not_early;
      s_first_access |-> !pready;
   endproperty
   a_not_early: assert property (p_not_early) else $error("pready in first access cycle");
   property p_err_qualified;
      pslverr |-> pready;
   endproperty
   a_err_qualified: assert property (p_err_qualified) else $error("pslverr without pready");
   property p_err_decode;
      s_done ##0 (paddr[1:0] == 2'h0) |->
         pslverr == ((paddr > 8'h1c) || (pwrite && paddr == SIU_REG_STATUS));
   endproperty
   a_err_decode: assert property (p_err_decode) else $error("wrong pslverr");
   property p_write_data_zero;
      s_done ##0 pwrite |-> prdata == 32'h0;
   endproperty
   a_write_data_zero: assert property (p_write_data_zero) else $error("prdata not zero on write");
   property p_unmapped_zero;
      s_done ##0 (paddr > 8'h1c) |-> prdata == 32'h0;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
   // The core runs four phases plus a settle cycle, so no answer may come sooner
   property p_insn_busy;
      s_done ##0 (pwrite && paddr == SIU_REG_INSN) |=> !pready [*5];
   endproperty
   a_insn_busy: assert property (p_insn_busy) else $error("answer during execution");
endmodule : siu_top_props

bind siu_top siu_top_props u_props (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));

// *** siu_top_test.sv ***
// Self-checking bench for the subtract instruction unit
`timescale 1ns/100ps
module siu_top_test
   import siu_pkg::*;
;
   logic        mclk = 1'h0;
   logic        rst = 1'h1;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] rd;
   logic        err;
   int          n_errors = 0;
   int          num_checks = 0;
   always #2.5 mclk = ~mclk;
   siu_top u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // ==========================================================
   // Bus and compare helpers
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      do begin
         @(posedge mclk);
         t++;
      end while (pready !== 1'h1 && t < 64);
      if (pready !== 1'h1) begin
         n_errors++;
         $display("unexpected at %0t: no pready on access to %h", $time, a);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge mclk);
   endtask : apb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(rd, exp);
   endtask : rdchk
   // Flags N OV Z DC C, carry meaning no borrow
   function automatic logic [31:0] flags(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] r;
      r = a - b;
      return {27'h0, r[7], (a[7] != b[7]) && (r[7] != a[7]), r == 8'h00, a[3:0] >= b[3:0], a >= b};
   endfunction : flags
   // ==========================================================
   // Scenarios
   task automatic t_literal();
      logic [7:0] ks [6] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'hff, 8'h10};
      logic [7:0] ws [6] = '{8'h01, 8'h02, 8'h03, 8'h80, 8'h00, 8'h01};
      rdchk(SIU_REG_STATUS, 32'h0);
      for (int i = 0; i < 6; i++) begin
         apb(1'h1, SIU_REG_WORK, {24'h0, ws[i]});
         apb(1'h1, SIU_REG_INSN, {16'h0, SIU_OP_LIT_MINUS_W, ks[i]});
         rdchk(SIU_REG_WORK, {24'h0, ks[i] - ws[i]});
         rdchk(SIU_REG_STATUS, flags(ks[i], ws[i]));
      end
   endtask : t_literal
   // Bank 2 and index base 0x300 keep every resolved address distinct
   task automatic file_op(input logic x, input logic a, input logic d, input logic [7:0] f,
                          input logic [11:0] ma);
      apb(1'h1, SIU_REG_CTRL, {31'h0, x});
      apb(1'h1, SIU_REG_BANK, 32'h2);
      apb(1'h1, SIU_REG_INDEX, 32'h300);
      apb(1'h1, SIU_REG_MEM_ADDR, {20'h0, ma});
      apb(1'h1, SIU_REG_MEM_DATA, 32'h53);
      apb(1'h1, SIU_REG_WORK, 32'h61);
      apb(1'h1, SIU_REG_INSN, {16'h0, SIU_OP_FILE_MINUS_W, d, a, f});
      rdchk(SIU_REG_WORK, d ? 32'h61 : 32'hf2);
      rdchk(SIU_REG_MEM_DATA, d ? 32'hf2 : 32'h53);
      rdchk(SIU_REG_STATUS, flags(8'h53, 8'h61));
   endtask : file_op
   task automatic t_file();
      file_op(1'h0, 1'h0, 1'h0, 8'h10, 12'h010);
      file_op(1'h0, 1'h0, 1'h1, 8'h80, 12'hf80);
      file_op(1'h0, 1'h1, 1'h1, 8'h20, 12'h220);
      file_op(1'h1, 1'h1, 1'h1, 8'h10, 12'h210);
      file_op(1'h1, 1'h0, 1'h1, 8'h10, 12'h310);
      file_op(1'h1, 1'h0, 1'h1, 8'h5f, 12'h35f);
      file_op(1'h1, 1'h0, 1'h1, 8'h60, 12'hf60);
   endtask : t_file
   task automatic t_refuse();
      apb(1'h0, 8'h20, 32'h0);
      chk({rd[31:1], err}, 32'h1);
      apb(1'h1, SIU_REG_STATUS, 32'h1f);
      chk({31'h0, err}, 32'h1);
      // Unknown opcode runs its phases but must leave W, memory and flags alone
      apb(1'h1, SIU_REG_INSN, 32'hffff);
      rdchk(SIU_REG_WORK, 32'h61);
      rdchk(SIU_REG_MEM_DATA, 32'hf2);
      rdchk(SIU_REG_STATUS, flags(8'h53, 8'h61));
   endtask : t_refuse
   // Reset with the core idle; CTRL, WORK, BANK, INDEX, STATUS and MEM_ADDR must read back as zero
   task automatic t_reset();
      rst <= 1'h1;
      repeat (2) @(posedge mclk);
      rst <= 1'h0;
      @(posedge mclk);
      rdchk(SIU_REG_CTRL, 32'h0);
      rdchk(SIU_REG_WORK, 32'h0);
      rdchk(SIU_REG_BANK, 32'h0);
      rdchk(SIU_REG_INDEX, 32'h0);
      rdchk(SIU_REG_STATUS, 32'h0);
      rdchk(SIU_REG_MEM_ADDR, 32'h0);
   endtask : t_reset
   task automatic final_report();
      $display("checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      final_report();
   end
   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'h0;
      @(posedge mclk);
      t_literal();
      t_file();
      t_refuse();
      t_reset();
      final_report();
   end
endmodule : siu_top_test
